/* rsc_pkg.sv */
package rsc_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int          RSC_NUM_PORTS    = 8;
    localparam int          RSC_ADDR_W       = 12;
    localparam int          RSC_NUM_CH       = 32;
    localparam logic [11:0] RSC_PORT_STRIDE  = 12'h200;

    // ---------------------------------------------------------------
    // register offsets within one port block
    // ---------------------------------------------------------------
    localparam logic [8:0] RSC_SIG_BASE      = 9'h040;
    localparam logic [8:0] RSC_SIG_LAST      = 9'h04f;
    localparam logic [8:0] RSC_LCV_HI        = 9'h050;
    localparam logic [8:0] RSC_LCV_LO        = 9'h051;
    localparam logic [8:0] RSC_PCV_HI        = 9'h052;
    localparam logic [8:0] RSC_PCV_LO        = 9'h053;
    localparam logic [8:0] RSC_FOS_HI        = 9'h054;
    localparam logic [8:0] RSC_FOS_LO        = 9'h055;

    // ---------------------------------------------------------------
    // reset values and layout
    // ---------------------------------------------------------------
    localparam logic [15:0] RSC_CNT_RESET    = 16'h0000;
    localparam logic [3:0]  RSC_SIG_RESET    = 4'h0;
    localparam int          RSC_T1_REGS      = 12;
    localparam int          RSC_T1_HALF      = 12;
    localparam int          RSC_E1_HALF      = 15;

    // host read timing for software (signaling loss avoidance)
    localparam real         RSC_D4_READ_MS   = 1.5;
    localparam real         RSC_ESF_READ_MS  = 3.0;

    // per-port event and capture bundle from the receive framer
    typedef struct packed {
        logic       sig_valid;   // capture strobe for one channel
        logic [4:0] sig_chan;    // zero-based channel index
        logic [3:0] sig_abcd;    // A at bit 3
        logic       line_err;    // one line code violation
        logic       path_err;    // one path code violation
        logic       unsync_frame; // one frame while out of sync
        logic       out_of_sync; // loss of sync level
    } rsc_rx_evt_t;

    // host register port
    typedef struct packed {
        logic [RSC_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
        logic                  wr;
        logic                  rd;
    } rsc_host_req_t;

endpackage : rsc_pkg

/* rsc_rx_sig_counters.sv */
// Behaviour
// - eight port copies, each at base plus 200h times port index 0..7
// - T1: twelve registers, channel k upper nibble, channel k+12 lower
// - E1: sixteen registers, first holds zero nibble and X Y X X
// - ESF framing captures A, B, C, D per channel
// - D4 framing captures A, B and repeats them into C, D
// - signaling frozen during loss of sync, keeping last values
// - 16-bit line code violation count at 050h high, 051h low
// - 16-bit path code violation count at 052h high, 053h low
// - 16-bit frames out of sync count at 054h high, 055h low
// - all six counter bytes read zero after reset
// - signaling registers sit at 040h through 04Fh
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module rsc_rx_sig_counters
    import rsc_pkg::*;
#(
    parameter int NUM_PORTS = rsc_pkg::RSC_NUM_PORTS
) (
    // clock, reset, enable
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    // per-port mode: 1 = E1 layout, 0 = T1 layout
    input  wire logic [NUM_PORTS-1:0]      e1_mode,
    // per-port framing: 1 = ESF, 0 = D4 (T1 only)
    input  wire logic [NUM_PORTS-1:0]      esf_mode,
    // per-port E1 X/Y/X/X spare bits for the first register
    input  wire logic [NUM_PORTS*4-1:0]    e1_xy_bits,
    // receive framer events, one bundle per port
    input  wire rsc_pkg::rsc_rx_evt_t      rx_evt [NUM_PORTS],
    // host register port
    input  wire rsc_pkg::rsc_host_req_t    host_req,
    output logic [7:0]                     rd_data
);
    import rsc_pkg::*;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [3:0]  sig_mem [NUM_PORTS][RSC_NUM_CH];
    logic [15:0] line_err_cnt [NUM_PORTS];
    logic [15:0] path_err_cnt [NUM_PORTS];
    logic [15:0] unsync_cnt   [NUM_PORTS];
    logic [7:0]  next_rd_data;

    // framer events per port, split out of the carrier
    logic [NUM_PORTS-1:0] cap_hit;
    logic [NUM_PORTS-1:0] line_hit;
    logic [NUM_PORTS-1:0] path_hit;
    logic [NUM_PORTS-1:0] unsync_hit;
    logic [3:0]           cap_abcd [NUM_PORTS];

    // host address split into port and offset
    logic [2:0]           req_port;
    logic [8:0]           req_off;
    logic                 req_port_ok;
    logic                 req_sig_win;
    logic                 req_cnt_win;
    logic [3:0]           req_sig_idx;
    logic [7:0]           sig_byte;
    logic [7:0]           cnt_byte;

    // ---------------------------------------------------------------
    // register map of one port block, port index in addr[11:9]
    // ---------------------------------------------------------------
    //   040h..04bh  T1: upper nibble channel k, lower nibble channel k+12
    //   04ch..04fh  T1: no register, reads zero
    //   040h        E1: zero nibble above the spare X Y X X bits
    //   041h..04fh  E1: upper nibble channel k-1, lower nibble channel k+14
    //   050h, 051h  line code violations, high byte then low byte
    //   052h, 053h  path code violations, high byte then low byte
    //   054h, 055h  frames counted out of sync, high byte then low byte
    //   elsewhere   reads zero
    //   channel numbers are zero-based, as carried on sig_chan
    //   nibble order is A B C D from bit 3 down to bit 0
    //   writes anywhere are dropped
    //   no latching: a tally read as two bytes may tear if an
    //   event lands between the two reads; software reads twice

    // saturating is not asked for: counters wrap like a free-running tally
    function automatic logic [15:0] bump(input logic [15:0] v, input logic ev);
        bump = ev ? v + 16'h0001 : v;
    endfunction : bump

    // fold D4 A/B into the C/D positions
    function automatic logic [3:0] fold_abcd(input logic [3:0] v, input logic esf, input logic e1);
        if (esf || e1) begin
            fold_abcd = v;
        end else begin
            fold_abcd = {v[3:2], v[3:2]};
        end
    endfunction : fold_abcd

    // upper or lower byte of a 16-bit tally
    function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
        if (hi) begin
            pick_byte = v[15:8];
        end else begin
            pick_byte = v[7:0];
        end
    endfunction : pick_byte

    // offset inside an inclusive span
    function automatic logic in_span(input logic [8:0] v, input logic [8:0] lo, input logic [8:0] hi);
        in_span = (v >= lo) && (v <= hi);
    endfunction : in_span

    // ---------------------------------------------------------------
    // framer event unpack
    // ---------------------------------------------------------------
    // a strobe during loss of sync is dropped, not deferred
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            cap_hit[p]    = rx_evt[p].sig_valid && !rx_evt[p].out_of_sync;
            line_hit[p]   = rx_evt[p].line_err;
            path_hit[p]   = rx_evt[p].path_err;
            unsync_hit[p] = rx_evt[p].unsync_frame;
            cap_abcd[p]   = fold_abcd(rx_evt[p].sig_abcd, esf_mode[p], e1_mode[p]);
        end
    end

    // ---------------------------------------------------------------
    // signaling capture
    // ---------------------------------------------------------------
    // ram-like array, cleared to RSC_SIG_RESET on reset; each capture fills one channel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int c = 0; c < RSC_NUM_CH; c++) begin
                    sig_mem[p][c] <= RSC_SIG_RESET;
                end
            end
        end else if (clk_en) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (cap_hit[p]) begin
                    sig_mem[p][rx_evt[p].sig_chan] <= cap_abcd[p];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // performance counters
    // ---------------------------------------------------------------
    // line code violations
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                line_err_cnt[p] <= RSC_CNT_RESET;
            end
        end else if (clk_en) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                line_err_cnt[p] <= bump(line_err_cnt[p], line_hit[p]);
            end
        end
    end

    // path code violations
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                path_err_cnt[p] <= RSC_CNT_RESET;
            end
        end else if (clk_en) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                path_err_cnt[p] <= bump(path_err_cnt[p], path_hit[p]);
            end
        end
    end

    // frames out of sync
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                unsync_cnt[p] <= RSC_CNT_RESET;
            end
        end else if (clk_en) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                unsync_cnt[p] <= bump(unsync_cnt[p], unsync_hit[p]);
            end
        end
    end

    // ---------------------------------------------------------------
    // host read decode
    // ---------------------------------------------------------------
    // writes ignored, reads pure: host_req.wr is never looked at
    // address split; upper bits pick the port copy
    always_comb begin
        req_port    = host_req.addr[11:9];
        req_off     = host_req.addr[8:0];
        req_port_ok = 32'(req_port) < NUM_PORTS;
        req_sig_win = in_span(req_off, RSC_SIG_BASE, RSC_SIG_LAST);
        req_cnt_win = in_span(req_off, RSC_LCV_HI, RSC_FOS_LO);
        req_sig_idx = 4'(req_off - RSC_SIG_BASE);
    end

    // signaling byte; both layouts share one lookup into the array
    always_comb begin
        int k;
        k        = int'(req_sig_idx);
        sig_byte = 8'h00;
        if (e1_mode[req_port]) begin
            if (k == 0) begin
                sig_byte = {4'h0, e1_xy_bits[req_port*4 +: 4]};
            end else begin
                sig_byte = {sig_mem[req_port][k-1], sig_mem[req_port][k-1+RSC_E1_HALF]};
            end
        end else if (k < RSC_T1_REGS) begin
            sig_byte = {sig_mem[req_port][k], sig_mem[req_port][k+RSC_T1_HALF]};
        end
    end

    // counter byte: even offset high half, odd offset low half
    always_comb begin
        cnt_byte = 8'h00;
        case (req_off)
            RSC_LCV_HI, RSC_LCV_LO: cnt_byte = pick_byte(line_err_cnt[req_port], req_off == RSC_LCV_HI);
            RSC_PCV_HI, RSC_PCV_LO: cnt_byte = pick_byte(path_err_cnt[req_port], req_off == RSC_PCV_HI);
            RSC_FOS_HI, RSC_FOS_LO: cnt_byte = pick_byte(unsync_cnt[req_port], req_off == RSC_FOS_HI);
            default: cnt_byte = 8'h00;
        endcase
    end

    // final pick; unmapped offsets and absent ports read zero
    always_comb begin
        next_rd_data = 8'h00;
        if (req_port_ok && req_sig_win) begin
            next_rd_data = sig_byte;
        end else if (req_port_ok && req_cnt_win) begin
            next_rd_data = cnt_byte;
        end
    end

    // read data one cycle after the strobe, zero on other enabled cycles, held while clk_en is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            rd_data <= host_req.rd ? next_rd_data : 8'h00;
        end
    end

endmodule : rsc_rx_sig_counters

`default_nettype wire

/* rsc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// port checks
// ---------------------------------------------
module rsc_chk
    import rsc_pkg::*;
#(parameter int NUM_PORTS = 8) (
    // clock and setup
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   clk_en,
    input wire logic [NUM_PORTS-1:0]   e1_mode,
    input wire logic [NUM_PORTS-1:0]   esf_mode,
    input wire logic [NUM_PORTS*4-1:0] e1_xy_bits,
    // framer and host
    input wire rsc_pkg::rsc_rx_evt_t   rx_evt [NUM_PORTS],
    input wire rsc_pkg::rsc_host_req_t host_req,
    input wire logic [7:0]             rd_data
);
    // decoded request fields
    wire logic [2:0] prt = host_req.addr[11:9];
    wire logic [8:0] off = host_req.addr[8:0];
    wire logic [3:0] xy  = e1_xy_bits[prt*4 +: 4];
    wire logic       rd  = clk_en && host_req.rd;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // two back-to-back reads of one counter byte
    sequence s_two(a, ev); rd && prt == 3'd0 && off == a && ev ##1 rd && prt == 3'd0 && off == a; endsequence
    property p_rst; disable iff (1'b0) rst && clk_en |=> rd_data == 8'h00; endproperty
    property p_idle; clk_en && !host_req.rd |=> rd_data == 8'h00; endproperty
    property p_unmap; rd && (off < RSC_SIG_BASE || off > RSC_FOS_LO) |=> rd_data == 8'h00; endproperty
    property p_hole; rd && !e1_mode[prt] && off >= 9'h04c && off <= RSC_SIG_LAST |=> rd_data == 8'h00; endproperty
    property p_first; rd && e1_mode[prt] && off == RSC_SIG_BASE |=> rd_data == {4'h0, $past(xy)}; endproperty
    property p_keep; s_two(RSC_LCV_LO, !rx_evt[0].line_err) |=> rd_data == $past(rd_data); endproperty
    property p_line; s_two(RSC_LCV_LO, rx_evt[0].line_err) |=> rd_data == 8'($past(rd_data) + 8'h01); endproperty
    property p_path; s_two(RSC_PCV_LO, rx_evt[0].path_err) |=> rd_data == 8'($past(rd_data) + 8'h01); endproperty
    property p_fos; s_two(RSC_FOS_LO, rx_evt[0].unsync_frame) |=> rd_data == 8'($past(rd_data) + 8'h01); endproperty
    a_rst: assert property (p_rst) else $error("read data not zero in reset");
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    a_unmap: assert property (p_unmap) else $error("unmapped offset not zero");
    a_hole: assert property (p_hole) else $error("unused T1 register not zero");
    a_first: assert property (p_first) else $error("first E1 register wrong");
    a_keep: assert property (p_keep) else $error("read changed a counter");
    a_line: assert property (p_line) else $error("line count did not step");
    a_path: assert property (p_path) else $error("path count did not step");
    a_fos: assert property (p_fos) else $error("unsync count did not step");
endmodule : rsc_chk
bind rsc_rx_sig_counters rsc_chk #(.NUM_PORTS(NUM_PORTS)) chk_u (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .e1_mode(e1_mode), .esf_mode(esf_mode), .e1_xy_bits(e1_xy_bits),
    .rx_evt(rx_evt), .host_req(host_req), .rd_data(rd_data));
`default_nettype wire

/* rsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// host cpu model
// ---------------------------------------------
module rsc_host_model
    import rsc_pkg::*;
(
    // clock
    input  wire logic                  sys_clk,
    // register port
    output var rsc_pkg::rsc_host_req_t host_req,
    input  wire logic [7:0]            rd_data
);
    initial host_req = '0;
    // write cycle, one strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        host_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    // reads repeat far inside the refresh span
    task automatic rd2(input logic [11:0] a, input bit two, output logic [7:0] d0, output logic [7:0] d1);
        @(posedge sys_clk);
        host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        if (two) begin
            @(negedge sys_clk);
            d0 = rd_data;
            @(posedge sys_clk);
        end
        // released address goes to a changed pattern
        host_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(negedge sys_clk);
        d1 = rd_data;
        if (!two) d0 = d1;
    endtask : rd2
endmodule : rsc_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// bench
// ---------------------------------------------
module testbench;
    import rsc_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    logic          clk_en = 1'b1;
    logic [7:0]    e1_mode = 8'h04;
    logic [7:0]    esf_mode = 8'h01;
    logic [31:0]   e1_xy_bits = 32'h0000_0500;
    rsc_rx_evt_t   rx_evt [8];
    rsc_host_req_t host_req;
    logic [7:0]    rd_data, d0, d1;
    int            fails = 0;
    int            check_count = 0;
    // captures as port, channel, abcd
    logic [11:0] caps [9] = '{12'h009, 12'h0c6, 12'h0b3, 12'h17c, 12'h25b, 12'h407, 12'h4fe, 12'h4e1, 12'h5d2};
    // address, expected read data
    logic [19:0] rows [16] = '{20'h25001, 20'h25101, 20'he5200, 20'he5302, 20'he5400, 20'he5501, 20'h05100,
        20'h04096, 20'h04b3c, 20'h04c00, 20'h245a0, 20'h44005, 20'h4417e, 20'h44f12, 20'h05600, 20'h03f00};
    always #5 sys_clk = ~sys_clk;
    rsc_rx_sig_counters dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .e1_mode(e1_mode),
        .esf_mode(esf_mode), .e1_xy_bits(e1_xy_bits), .rx_evt(rx_evt), .host_req(host_req), .rd_data(rd_data));
    rsc_host_model host_u (.sys_clk(sys_clk), .host_req(host_req), .rd_data(rd_data));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: read %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one framer pulse: 0 capture, 1 line, 2 path, 3 unsync
    task automatic ev(input int p, input int k, input logic [4:0] ch, input logic [3:0] s);
        @(posedge sys_clk);
        rx_evt[p] <= {k == 0, ch, s, k == 1, k == 2, k == 3, rx_evt[p].out_of_sync};
        @(posedge sys_clk);
        rx_evt[p] <= {13'h0, rx_evt[p].out_of_sync};
    endtask : ev
    task automatic summarize;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // watchdog, far beyond the several hundred cycles needed
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        foreach (rx_evt[i]) rx_evt[i] = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int o = 0; o < 6; o++) begin
            host_u.rd2(12'(12'he50 + o), 1'b0, d0, d1);
            chk(d0, 8'h00);
        end
        repeat (257) ev(1, 1, 5'd0, 4'h0);
        repeat (2) ev(7, 2, 5'd0, 4'h0);
        ev(7, 3, 5'd0, 4'h0);
        foreach (caps[i]) ev(int'(caps[i][11:9]), 0, caps[i][8:4], caps[i][3:0]);
        foreach (rows[i]) begin
            host_u.rd2(rows[i][19:8], 1'b0, d0, d1);
            chk(d0, rows[i][7:0]);
        end
        // capture while out of sync must not land
        @(posedge sys_clk);
        rx_evt[0].out_of_sync <= 1'b1;
        ev(0, 0, 5'd0, 4'h1);
        @(posedge sys_clk);
        rx_evt[0].out_of_sync <= 1'b0;
        host_u.wr(12'h251, 8'hff);
        host_u.wr(12'h040, 8'h00);
        host_u.rd2(12'h040, 1'b0, d0, d1);
        chk(d0, 8'h96);
        host_u.rd2(12'h251, 1'b1, d0, d1);
        chk(d0, 8'h01);
        chk(d1, 8'h01);
        for (int k = 1; k < 4; k++) begin
            fork
                host_u.rd2(12'(12'h04f + 2 * k), 1'b1, d0, d1);
                ev(0, k, 5'd0, 4'h0);
            join
            chk(d1, 8'(d0 + 8'h01));
        end
        // event while the enable is low must not count
        @(posedge sys_clk);
        clk_en <= 1'b0;
        ev(0, 1, 5'd0, 4'h0);
        clk_en <= 1'b1;
        host_u.rd2(12'h051, 1'b0, d0, d1);
        chk(d0, 8'h01);
        // second reset in mid run
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        host_u.rd2(12'h251, 1'b0, d0, d1);
        chk(d0, 8'h00);
        summarize();
    end
endmodule : testbench
`default_nettype wire
